// ---- core/dfc_ctrl.sv ----
// Function
// - Switch-on bit rising leaves switch-on inhibit into ready-to-run.
// - Switch-on bit low ramps down, then ready-to-switch-on.
// - Coast-stop bit low removes output at once, enters inhibit.
// - Quick-stop bit low runs the configured quick-stop behaviour.
// - Start bit runs the drive; clearing it stops by stop function.
// - Ramp-enable low forces ramp output zero; overrides hold, setpoint.
// - Ramp-release low freezes the ramp; overrides setpoint enable.
// - Setpoint-enable low forces reference zero; lowest ramp priority.
// - Faults acknowledged on fault-reset rising edge; may enter inhibit.
// - An inching bit runs the matching constant speed while set.
// - Bus word, except its watchdog bit, acts only when enabled and control place is fieldbus.
// - Master toggles watchdog bit about 1 s; loss raises fault.
// - Bus jog is start with all three ramp bits at zero.
// - Bus jog accepted only at zero speed; ramp bits resume after.
// - Local jog starts without start command, needs jog-enable input.
// - Inching ignored while start is active from the control place.
// - Both inching requests at once stop the drive.
// - Status fault, warning, running, ready from drive; bits 0-2, 4-6, 9 from board.
// - Status at-reference bit set when actual speed equals reference.
// - Status top bit echoes received watchdog bit.
// - Watchdog supervised only with non-zero timeout; loss means fault.
// - Bus control withdrawn while running gives a coasting stop.
`timescale 1ns/1ps
module dfc_ctrl #(
   parameter int unsigned CYC_PER_MS = dfc_pkg::WD_MS_CYC
) (
   input wire logic i_clock, // System clock, 50 MHz
   input wire logic i_sys_rst, // Synchronous reset, active high
   input wire logic i_cw_valid, // One-cycle strobe per bus cycle
   input wire dfc_pkg::dfc_cw_t i_bus_drive_control_word, // Control word
   input wire logic [1:0] i_control_place_select, // 3 selects fieldbus
   input wire logic [15:0] i_watchdog_timeout_setting, // ms, 0 = off
   input wire logic i_local_start, // Start from non-bus place
   input wire logic [1:0] i_stop_cfg, // Normal stop function
   input wire logic [1:0] i_qstop_cfg, // Quick-stop function
   input wire logic i_drive_fault, // Drive fault present
   input wire logic i_fault_volt_removed, // Fault reaction cut voltage
   input wire logic i_warning, // Drive warning present
   input wire logic i_zero_speed, // Motor at zero speed
   input wire logic [15:0] i_speed_actual, // Actual speed
   input wire logic [15:0] i_speed_reference_primary, // Speed reference
   input wire logic i_io_jog_enable, // Digital jog-enable input
   input wire logic i_io_jog1, // Local jog 1 request
   input wire logic i_io_jog2, // Local jog 2 request
   input wire logic [15:0] i_interface_board_state_machine, // Board bits
   output dfc_pkg::dfc_cmd_t o_drive_cmd, // Registered drive actions
   output logic [15:0] o_combo1_drive_status_word, // Status word
   output logic o_comm_fault, // Watchdog communication fault
   output dfc_pkg::dfc_state_e o_state // Present drive state
);
   import dfc_pkg::*;

   typedef struct packed {
      dfc_cw_t cw;
      dfc_state_e state;
      logic jog;
      logic bus_act;
      dfc_cmd_t cmd;
      logic [15:0] status;
   } dfc_top_st_t;

   dfc_top_st_t st_ff;
   dfc_top_st_t nxt_st;
   logic wd_fault;

   dfc_wdog #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_wdog (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_wd_bit(st_ff.cw.wdog),
      .i_timeout_ms(i_watchdog_timeout_setting),
      .i_clear(st_ff.cmd.fault_ack),
      .o_fault(wd_fault)
   );

   always_comb begin
      logic bus_act;
      logic on_rise;
      logic rst_rise;
      logic fault_any;
      logic modulating;
      logic bus_jog;
      logic inch;
      logic io_jog;
      logic j1;
      logic j2;
      logic jog_req;
      logic norm_start;
      dfc_cw_t w;
      bus_act = 1'b0;
      on_rise = 1'b0;
      rst_rise = 1'b0;
      fault_any = 1'b0;
      modulating = 1'b0;
      bus_jog = 1'b0;
      inch = 1'b0;
      io_jog = 1'b0;
      j1 = 1'b0;
      j2 = 1'b0;
      jog_req = 1'b0;
      norm_start = 1'b0;
      w = st_ff.cw;
      nxt_st = st_ff;
      nxt_st.cmd.fault_ack = 1'b0;

      if (i_cw_valid) begin
         nxt_st.cw = i_bus_drive_control_word;
      end
      bus_act = st_ff.cw.fb_en &&
         i_control_place_select == CP_FIELDBUS;
      nxt_st.bus_act = bus_act;
      // Edges compare the arriving word with the one held
      on_rise = bus_act & i_cw_valid & i_bus_drive_control_word.on &
         ~st_ff.cw.on;
      rst_rise = bus_act & i_cw_valid &
         i_bus_drive_control_word.fault_rst & ~st_ff.cw.fault_rst;

      // Off the bus, the word is replaced by a benign local one
      if (!bus_act) begin
         w = CW_RST;
         w.on = 1'b1;
         w.coast_n = 1'b1;
         w.qstop_n = 1'b1;
         w.ramp_en = 1'b1;
         w.ramp_rel = 1'b1;
         w.sp_en = 1'b1;
         w.start = i_local_start;
      end

      fault_any = i_drive_fault | wd_fault;
      modulating = st_ff.state == ST_RUN || st_ff.state == ST_STOP ||
         st_ff.state == ST_QSTOP;

      bus_jog = bus_act & w.start & ~w.ramp_en & ~w.ramp_rel &
         ~w.sp_en;
      inch = bus_act & ~w.start & (w.inch1 | w.inch2);
      io_jog = i_io_jog_enable & ~w.start &
         (i_io_jog1 | i_io_jog2);
      // Bus jog without an inching bit follows the first jog speed
      j1 = (bus_jog & (w.inch1 | ~w.inch2)) | (inch & w.inch1) |
         (io_jog & i_io_jog1);
      j2 = (bus_jog & w.inch2) | (inch & w.inch2) | (io_jog & i_io_jog2);
      jog_req = j1 ^ j2;
      norm_start = w.start & ~bus_jog;

      unique case (st_ff.state)
         ST_INHIBIT: begin
            if ((bus_act ? on_rise : 1'b1) && w.coast_n && w.qstop_n) begin
               nxt_st.state = ST_READY;
            end
         end
         ST_SWON: begin
            if (w.on) begin
               nxt_st.state = ST_READY;
            end
         end
         ST_READY: begin
            if (!w.on) begin
               nxt_st.state = ST_SWON;
            end else if (norm_start) begin
               nxt_st.state = ST_RUN;
            end else if (jog_req && i_zero_speed) begin
               nxt_st.state = ST_RUN;
               nxt_st.jog = 1'b1;
            end
         end
         ST_RUN: begin
            if (!w.on) begin
               nxt_st.state = ST_STOP;
            end else if (st_ff.jog ? !jog_req : !norm_start) begin
               nxt_st.state = ST_STOP;
            end
         end
         ST_STOP: begin
            if (i_zero_speed) begin
               nxt_st.jog = 1'b0;
               nxt_st.state = w.on ? ST_READY : ST_SWON;
            end else if (!st_ff.jog && w.on && norm_start) begin
               nxt_st.state = ST_RUN;
            end
         end
         ST_QSTOP: begin
            if (i_zero_speed) begin
               nxt_st.state = ST_INHIBIT;
            end
         end
         ST_FAULT: begin
            if (rst_rise && !fault_any) begin
               nxt_st.state = i_fault_volt_removed ?
                  ST_INHIBIT : ST_SWON;
            end
         end
         default: begin
            nxt_st.state = ST_INHIBIT;
         end
      endcase

      // Fault, then coast, then quick stop, in that precedence
      if (fault_any && st_ff.state != ST_FAULT) begin
         nxt_st.state = ST_FAULT;
         nxt_st.jog = 1'b0;
      end else if (st_ff.state != ST_FAULT &&
         (!w.coast_n || (st_ff.bus_act && !bus_act && modulating))) begin
         nxt_st.state = ST_INHIBIT;
         nxt_st.jog = 1'b0;
      end else if (!w.qstop_n && st_ff.state != ST_FAULT &&
         st_ff.state != ST_INHIBIT && st_ff.state != ST_QSTOP) begin
         nxt_st.state = modulating ? ST_QSTOP : ST_INHIBIT;
         nxt_st.jog = 1'b0;
      end

      nxt_st.cmd.fault_ack = rst_rise;
      nxt_st.cmd.modulate = nxt_st.state == ST_RUN ||
         nxt_st.state == ST_STOP || nxt_st.state == ST_QSTOP;
      nxt_st.cmd.coast = ~nxt_st.cmd.modulate;
      unique case (nxt_st.state)
         ST_STOP: nxt_st.cmd.stop_func = i_stop_cfg;
         ST_QSTOP: nxt_st.cmd.stop_func = i_qstop_cfg;
         default: nxt_st.cmd.stop_func = STOP_NONE;
      endcase

      // Ramp bits have no say while a jog is in progress
      if (nxt_st.jog) begin
         nxt_st.cmd.ramp_zero = 1'b0;
         nxt_st.cmd.ramp_hold = 1'b0;
         nxt_st.cmd.sp_zero = 1'b0;
      end else begin
         nxt_st.cmd.ramp_zero = ~w.ramp_en;
         nxt_st.cmd.ramp_hold = w.ramp_en & ~w.ramp_rel;
         nxt_st.cmd.sp_zero = w.ramp_en & w.ramp_rel & ~w.sp_en;
      end
      // Dropping the selection lets the jog decelerate to zero
      if (nxt_st.jog && nxt_st.state == ST_RUN) begin
         nxt_st.cmd.jog_sel = {j2, j1};
      end else begin
         nxt_st.cmd.jog_sel = 2'h0;
      end

      nxt_st.status = i_interface_board_state_machine &
         SW_BOARD_MASK;
      nxt_st.status[SW_FAULT] = nxt_st.state == ST_FAULT;
      nxt_st.status[SW_WARN] = i_warning;
      nxt_st.status[SW_AT_REF] =
         i_speed_actual == i_speed_reference_primary;
      nxt_st.status[SW_RUNNING] = nxt_st.cmd.modulate;
      nxt_st.status[SW_READY] = nxt_st.state != ST_FAULT &&
         nxt_st.state != ST_INHIBIT;
      nxt_st.status[SW_WD_ECHO] = nxt_st.cw.wdog;
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         st_ff.cw <= dfc_cw_t'(CW_RST);
         st_ff.state <= ST_INHIBIT;
         st_ff.jog <= 1'b0;
         st_ff.bus_act <= 1'b0;
         st_ff.cmd <= '0;
         st_ff.status <= SW_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_drive_cmd = st_ff.cmd;
   assign o_combo1_drive_status_word = st_ff.status;
   assign o_comm_fault = wd_fault;
   assign o_state = st_ff.state;

endmodule

// ---- core/dfc_pkg.sv ----
package dfc_pkg;

   // Control word as latched from the bus, bit 0 in the lowest position
   typedef struct packed {
      logic [3:0] spare;
      logic wdog;
      logic fb_en;
      logic inch2;
      logic inch1;
      logic fault_rst;
      logic sp_en;
      logic ramp_rel;
      logic ramp_en;
      logic start;
      logic qstop_n;
      logic coast_n;
      logic on;
   } dfc_cw_t;

   // Gray codes along switch-on, run and stop
   typedef enum logic [2:0] {
      ST_INHIBIT = 3'h0,
      ST_SWON = 3'h1,
      ST_READY = 3'h3,
      ST_RUN = 3'h2,
      ST_STOP = 3'h6,
      ST_QSTOP = 3'h7,
      ST_FAULT = 3'h5
   } dfc_state_e;

   typedef struct packed {
      logic modulate;
      logic coast;
      logic [1:0] stop_func;
      logic ramp_zero;
      logic ramp_hold;
      logic sp_zero;
      logic [1:0] jog_sel;
      logic fault_ack;
   } dfc_cmd_t;

   localparam logic [15:0] CW_RST = 16'h0000;
   localparam logic [1:0] CP_FIELDBUS = 2'h3;
   localparam logic [1:0] STOP_NONE = 2'h0;

   // Status word layout
   localparam int SW_FAULT = 3;
   localparam int SW_WARN = 7;
   localparam int SW_AT_REF = 8;
   localparam int SW_RUNNING = 12;
   localparam int SW_READY = 13;
   localparam int SW_WD_ECHO = 15;
   localparam logic [15:0] SW_BOARD_MASK = 16'h0277;
   localparam logic [15:0] SW_RST = 16'h0000;

   // Watchdog timeout setting counts in milliseconds
   localparam int CLK_MHZ = 50;
   localparam int WD_UNIT_US = 1000;
   localparam int WD_MS_CYC = WD_UNIT_US * CLK_MHZ;
   localparam logic [15:0] WD_CNT_RST = 16'h0000;

endpackage

// ---- core/dfc_wdog.sv ----
`timescale 1ns/1ps
module dfc_wdog #(
   parameter int unsigned CYC_PER_MS = dfc_pkg::WD_MS_CYC
) (
   input wire logic i_clock, // System clock
   input wire logic i_sys_rst, // Synchronous reset
   input wire logic i_wd_bit, // Latched watchdog bit
   input wire logic [15:0] i_timeout_ms, // Zero disables supervision
   input wire logic i_clear, // Fault acknowledge pulse
   output logic o_fault // Sticky communication fault
);
   import dfc_pkg::*;

   typedef struct packed {
      logic prev;
      logic [15:0] presc;
      logic [15:0] ms_cnt;
      logic fault;
   } dfc_wd_st_t;

   dfc_wd_st_t wd_ff;
   dfc_wd_st_t nxt_wd;

   always_comb begin
      nxt_wd = wd_ff;
      nxt_wd.prev = i_wd_bit;
      if (i_clear) begin
         nxt_wd.fault = 1'b0;
      end
      // Any edge of the square wave proves the master is alive
      if (i_timeout_ms == 16'h0000 || i_wd_bit != wd_ff.prev) begin
         nxt_wd.presc = WD_CNT_RST;
         nxt_wd.ms_cnt = WD_CNT_RST;
      end else if (wd_ff.ms_cnt >= i_timeout_ms) begin
         // Timeout beats a clear landing in the same cycle
         nxt_wd.fault = 1'b1;
      end else if (wd_ff.presc == 16'(CYC_PER_MS - 1)) begin
         nxt_wd.presc = WD_CNT_RST;
         nxt_wd.ms_cnt = wd_ff.ms_cnt + 16'h0001;
      end else begin
         nxt_wd.presc = wd_ff.presc + 16'h0001;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         wd_ff <= '0;
      end else begin
         wd_ff <= nxt_wd;
      end
   end

   assign o_fault = wd_ff.fault;

endmodule

// ---- sim/dfc_bus_master.sv ----
`timescale 1ns/1ps
module dfc_bus_master (
   input wire logic i_clock, // clock
   output logic o_cw_valid, // word strobe
   output dfc_pkg::dfc_cw_t o_cw // control word
);
   import dfc_pkg::*;
   logic wd_ff = 1'b0;
   initial begin
      o_cw_valid = 1'b0;
      o_cw = 16'hffff;
   end
   // One word per call; released bus shows the inverse, not the last word
   task automatic send(input logic [15:0] w);
      logic [15:0] v;
      @(posedge i_clock);
      wd_ff = ~wd_ff;
      v = {w[15:12], wd_ff, w[10:0]};
      o_cw_valid <= 1'b1;
      o_cw <= v;
      @(posedge i_clock);
      o_cw_valid <= 1'b0;
      o_cw <= ~v;
   endtask
endmodule

// ---- sim/dfc_ctrl_monitor.sv ----
`timescale 1ns/1ps
module dfc_ctrl_monitor #(
   parameter int unsigned CYC_PER_MS = dfc_pkg::WD_MS_CYC
) (
   input wire logic i_clock, // clock
   input wire logic i_sys_rst, // reset
   input wire logic i_cw_valid, // strobe
   input wire dfc_pkg::dfc_cw_t i_bus_drive_control_word, // word
   input wire logic [1:0] i_control_place_select, // place
   input wire logic [15:0] i_watchdog_timeout_setting, // ms
   input wire logic i_local_start, // start
   input wire logic [1:0] i_stop_cfg, // stop
   input wire logic [1:0] i_qstop_cfg, // qstop
   input wire logic i_drive_fault, // fault
   input wire logic i_fault_volt_removed, // volt off
   input wire logic i_warning, // warning
   input wire logic i_zero_speed, // zero
   input wire logic [15:0] i_speed_actual, // speed
   input wire logic [15:0] i_speed_reference_primary, // ref
   input wire logic i_io_jog_enable, // jog en
   input wire logic i_io_jog1, // jog 1
   input wire logic i_io_jog2, // jog 2
   input wire logic [15:0] i_interface_board_state_machine, // board
   input wire dfc_pkg::dfc_cmd_t o_drive_cmd, // cmd
   input wire logic [15:0] o_combo1_drive_status_word, // status
   input wire logic o_comm_fault, // comm fault
   input wire dfc_pkg::dfc_state_e o_state // state
);
   import dfc_pkg::*;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   chk_fault_entry: assert property (
      i_drive_fault |=> o_state == ST_FAULT)
      else $error("fault did not enter fault state");
   chk_ack_pulse: assert property (
      o_drive_cmd.fault_ack |=> !o_drive_cmd.fault_ack)
      else $error("fault acknowledge longer than one cycle");
   chk_inhibit_coast: assert property (
      o_state == ST_INHIBIT |-> ##[0:1] !o_drive_cmd.modulate)
      else $error("modulating in switch-on inhibit");
   chk_fault_bit: assert property (
      o_state == ST_FAULT |-> ##[0:1] o_combo1_drive_status_word[SW_FAULT])
      else $error("status fault bit missing");
   chk_board_bits: assert property (
      !$past(i_sys_rst) |-> (o_combo1_drive_status_word & SW_BOARD_MASK)
      == ($past(i_interface_board_state_machine) & SW_BOARD_MASK))
      else $error("board bits not copied");
   chk_warn_bit: assert property (
      !$past(i_sys_rst) |->
      o_combo1_drive_status_word[SW_WARN] == $past(i_warning))
      else $error("warning bit wrong");
   chk_at_ref: assert property (
      !$past(i_sys_rst) |-> o_combo1_drive_status_word[SW_AT_REF] ==
      ($past(i_speed_actual) == $past(i_speed_reference_primary)))
      else $error("at-reference bit wrong");
   chk_ready_bit: assert property (
      o_state == ST_INHIBIT |-> ##[0:1] !o_combo1_drive_status_word[SW_READY])
      else $error("ready bit set in inhibit");
   chk_wd_enable: assert property (
      $rose(o_comm_fault) |-> $past(i_watchdog_timeout_setting) != 16'h0000)
      else $error("watchdog fault while supervision off");
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
   import dfc_pkg::*;
   logic i_clock = 1'b0, i_sys_rst = 1'b1, i_cw_valid, i_local_start = 1'b0;
   logic i_drive_fault = 1'b0, i_fault_volt_removed = 1'b0, i_warning = 1'b0;
   logic i_zero_speed = 1'b0, i_io_jog_enable = 1'b0, i_io_jog1 = 1'b0;
   logic i_io_jog2 = 1'b0, o_comm_fault, ack_seen = 1'b0;
   logic [1:0] i_control_place_select = CP_FIELDBUS, i_qstop_cfg = 2'h1;
   logic [1:0] i_stop_cfg = 2'h2;
   logic [15:0] i_watchdog_timeout_setting = 16'h0000;
   logic [15:0] i_speed_actual = 16'h0010;
   logic [15:0] i_speed_reference_primary = 16'h0010;
   logic [15:0] i_interface_board_state_machine = 16'h0255;
   logic [15:0] o_combo1_drive_status_word;
   dfc_cw_t i_bus_drive_control_word;
   dfc_cmd_t o_drive_cmd;
   dfc_state_e o_state;
   logic [2:0] ramp_cmd;
   int bad_count = 0, n_tests = 0, cyc = 0;
   // Short watchdog unit keeps the supervision test to a few cycles
   dfc_ctrl #(.CYC_PER_MS(4)) uut (.*);
   dfc_bus_master mst (.i_clock(i_clock), .o_cw_valid(i_cw_valid),
      .o_cw(i_bus_drive_control_word));
   always #10 i_clock = ~i_clock;
   assign ramp_cmd = {o_drive_cmd.ramp_zero, o_drive_cmd.ramp_hold,
      o_drive_cmd.sp_zero};
   always @(posedge i_clock) begin
      if (o_drive_cmd.fault_ack === 1'b1) ack_seen <= 1'b1;
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Word plus three edges of latency, then the echoed watchdog bit
   task automatic send(input logic [15:0] w);
      mst.send(w);
      repeat (3) @(posedge i_clock);
      #1;
      `CHK("wd echo", mst.wd_ff, o_combo1_drive_status_word[SW_WD_ECHO])
   endtask
   task automatic st(input dfc_state_e e);
      `CHK("state", e, o_state)
   endtask
   initial begin
      repeat (8) @(posedge i_clock);
      #1;
      `CHK("status rst", SW_RST, o_combo1_drive_status_word)
      @(posedge i_clock);
      i_sys_rst <= 1'b0;
      send(16'h0406);
      send(16'h0407);
      st(ST_READY);
      send(16'h047f);
      st(ST_RUN);
      `CHK("running", 1'b1, o_combo1_drive_status_word[SW_RUNNING])
      `CHK("ramp", 3'h0, ramp_cmd)
      send(16'h044f);
      `CHK("ramp zero", 3'h4, ramp_cmd)
      send(16'h041f);
      `CHK("ramp hold", 3'h2, ramp_cmd)
      send(16'h043f);
      `CHK("sp zero", 3'h1, ramp_cmd)
      st(ST_RUN);
      send(16'h0477);
      st(ST_STOP);
      `CHK("stop func", i_stop_cfg, o_drive_cmd.stop_func)
      @(posedge i_clock);
      i_zero_speed <= 1'b1;
      repeat (3) @(posedge i_clock);
      #1;
      st(ST_READY);
      send(16'h040f);
      st(ST_RUN);
      `CHK("jog sel", 2'h1, o_drive_cmd.jog_sel)
      `CHK("jog ramp", 3'h0, ramp_cmd)
      send(16'h0407);
      repeat (3) @(posedge i_clock);
      #1;
      st(ST_READY);
      send(16'h0707);
      st(ST_READY);
      send(16'h0607);
      st(ST_RUN);
      `CHK("inch sel", 2'h2, o_drive_cmd.jog_sel)
      send(16'h0407);
      st(ST_READY);
      @(posedge i_clock);
      i_io_jog_enable <= 1'b1;
      i_io_jog1 <= 1'b1;
      repeat (3) @(posedge i_clock);
      #1;
      `CHK("io jog", 2'h1, o_drive_cmd.jog_sel)
      @(posedge i_clock);
      i_io_jog_enable <= 1'b0;
      repeat (3) @(posedge i_clock);
      #1;
      st(ST_READY);
      @(posedge i_clock);
      i_zero_speed <= 1'b0;
      send(16'h047f);
      send(16'h047b);
      st(ST_QSTOP);
      `CHK("qstop func", i_qstop_cfg, o_drive_cmd.stop_func)
      @(posedge i_clock);
      i_zero_speed <= 1'b1;
      repeat (2) @(posedge i_clock);
      #1;
      st(ST_INHIBIT);
      send(16'h047e);
      send(16'h047f);
      st(ST_RUN);
      send(16'h047d);
      st(ST_INHIBIT);
      `CHK("modulate", 1'b0, o_drive_cmd.modulate)
      `CHK("coast", 1'b1, o_drive_cmd.coast)
      @(posedge i_clock);
      i_drive_fault <= 1'b1;
      i_fault_volt_removed <= 1'b1;
      i_warning <= 1'b1;
      i_speed_actual <= 16'h0005;
      repeat (2) @(posedge i_clock);
      #1;
      st(ST_FAULT);
      `CHK("fault bit", 1'b1, o_combo1_drive_status_word[SW_FAULT])
      @(posedge i_clock);
      i_drive_fault <= 1'b0;
      send(16'h0487);
      st(ST_INHIBIT);
      `CHK("fault ack", 1'b1, ack_seen)
      `CHK("comm off", 1'b0, o_comm_fault)
      send(16'h047e);
      send(16'h047f);
      st(ST_RUN);
      @(posedge i_clock);
      i_control_place_select <= 2'h0;
      @(posedge i_clock);
      #1;
      st(ST_INHIBIT);
      `CHK("withdrawn", 1'b1, o_drive_cmd.coast)
      @(posedge i_clock);
      i_watchdog_timeout_setting <= 16'h0001;
      repeat (20) @(posedge i_clock);
      #1;
      `CHK("comm fault", 1'b1, o_comm_fault)
      end_of_test();
   end
endmodule
bind dfc_ctrl dfc_ctrl_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (.*);
